// ### hw/mdb_dev.sv
// Device end: read and write burst data path of the low-power DDR memory.
// Assumes the controller keeps its own spacing rules; CL must be 3 or more.
`timescale 1ns/1ns
`include "mdb_regs.svh"
module mdb_dev #(
  parameter int DW = 32,
  parameter int CW = 4,
  parameter int BL = 4,
  parameter int CL = 3
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  mdb_link_if.dev                      lnk,
  output logic [`MDB_NBANK-1:0]        o_bank_open,
  output logic                         o_write_active
);
  import mdb_pkg::*;

  localparam int NB = DW / 8;
  localparam int PL = CL - 1;
  localparam int AW = 2 + CW;
  localparam logic [4:0] PAIRS = 5'(BL / 2);
  localparam logic [`MDB_CNT_W-1:0] ROW_ACTIVE_TIME_C = `MDB_CNT_W'(`MDB_CYC_UP(`MDB_ROW_ACTIVE_TIME_NS));
  localparam logic [`MDB_CNT_W-1:0] TRP_C  = `MDB_CNT_W'(`MDB_CYC_UP(`MDB_TRP_NS));
  localparam logic [`MDB_CNT_W-1:0] TWR_C  = `MDB_CNT_W'(`MDB_CYC_UP(`MDB_TWR_NS));

  typedef struct packed {
    logic [CW-1:0]                          rd_col;
    logic [1:0]                             rd_bank;
    logic [4:0]                             rd_left;
    logic [PL-1:0]                          pv;
    logic [PL-1:0][1:0]                     pb;
    logic [PL-1:0][CW-1:0]                  pc;
    logic [CW-1:0]                          wr_col;
    logic [1:0]                             wr_bank;
    logic [4:0]                             wr_left;
    logic                                   wr_act;
    logic [NB-1:0]                          stb_last;
    logic [`MDB_NBANK-1:0]                  open;
    logic [`MDB_NBANK-1:0]                  ap_on;
    logic [`MDB_NBANK-1:0][`MDB_CNT_W-1:0]  ras;
    logic [`MDB_NBANK-1:0][`MDB_CNT_W-1:0]  apc;
    logic [`MDB_NBANK-1:0][`MDB_CNT_W-1:0]  rp;
    logic [2*DW-1:0]                        dq;
    logic                                   dq_oe;
    logic [2*NB-1:0]                        dqs;
    logic                                   dqs_oe;
  } mdb_dev_state_type;

  mdb_dev_state_type  s_reg;
  mdb_dev_state_type  s_next;
  logic [DW-1:0]      mem [2**AW];
  logic [NB-1:0]      we0;
  logic [NB-1:0]      we1;
  logic [AW-1:0]      wa0;
  logic [AW-1:0]      wa1;
  logic [AW-1:0]      ra0;
  logic [AW-1:0]      ra1;
  logic               slot;
  logic [1:0]         slot_b;
  logic [CW-1:0]      slot_c;
  logic               bank_ok;
  logic               acc_rd;
  logic               acc_wr;

  // Precharge aimed at this bank, or at all banks
  function automatic logic pre_hit(input mdb_cmd_type c, input logic all,
                                   input logic [1:0] cb, input logic [1:0] b);
    pre_hit = (c == CMD_PRE) && (all || (cb == b));
  endfunction : pre_hit

  assign bank_ok = s_reg.open[lnk.bank] && !s_reg.ap_on[lnk.bank];
  assign acc_rd  = (lnk.cmd == CMD_READ) && bank_ok;
  assign acc_wr  = (lnk.cmd == CMD_WRITE) && bank_ok;
  assign wa0     = {s_reg.wr_bank, s_reg.wr_col};
  assign wa1     = {s_reg.wr_bank, CW'(s_reg.wr_col + 1'b1)};
  assign ra0     = {s_reg.pb[PL-1], s_reg.pc[PL-1]};
  assign ra1     = {s_reg.pb[PL-1], CW'(s_reg.pc[PL-1] + 1'b1)};

  // Per-lane write capture: rising edge takes element 0, falling edge element 1
  for (genvar l = 0; l < NB; l++) begin : g_lane
    assign we0[l] = s_reg.wr_act && !s_reg.stb_last[l] && lnk.dqs_bus[2*l]
                    && !lnk.byte_write_mask[l];
    assign we1[l] = s_reg.wr_act && lnk.dqs_bus[2*l] && !lnk.dqs_bus[2*l+1]
                    && !lnk.byte_write_mask[NB+l];
  end

  always_comb begin
    s_next = s_reg;
    slot   = 1'b0;
    slot_b = s_reg.rd_bank;
    slot_c = s_reg.rd_col;

    // Bank state: open rows, row active time, auto-precharge, precharge time
    for (int b = 0; b < `MDB_NBANK; b++) begin
      if (s_reg.rp[b] != '0) begin
        s_next.rp[b] = s_reg.rp[b] - 1'b1;
      end
      if (s_reg.open[b] && s_reg.ras[b] != ROW_ACTIVE_TIME_C) begin
        s_next.ras[b] = s_reg.ras[b] + 1'b1;
      end
      if (s_reg.ap_on[b]) begin
        if (s_reg.apc[b] != '0) begin
          s_next.apc[b] = s_reg.apc[b] - 1'b1;
        end else if (s_reg.ras[b] == ROW_ACTIVE_TIME_C) begin
          s_next.ap_on[b] = 1'b0;
          s_next.open[b]  = 1'b0;
          s_next.rp[b]    = TRP_C;
        end
      end
      if (lnk.cmd == CMD_ACT && lnk.bank == 2'(b) && !s_reg.open[b]
          && s_reg.rp[b] == '0) begin
        s_next.open[b] = 1'b1;
        s_next.ras[b]  = '0;
      end
      if (pre_hit(lnk.cmd, lnk.auto_pre, lnk.bank, 2'(b)) && s_reg.open[b]
          && !s_reg.ap_on[b]) begin
        s_next.open[b] = 1'b0;
        s_next.rp[b]   = TRP_C;
      end
      if ((acc_rd || acc_wr) && lnk.auto_pre && lnk.bank == 2'(b)) begin
        s_next.ap_on[b] = 1'b1;
        s_next.apc[b]   = acc_rd ? `MDB_CNT_W'(PAIRS - 1'b1)
                                 : `MDB_CNT_W'(PAIRS) + TWR_C;
      end
    end

    // Read pair generator; an accepted new read, any stop or write, or a precharge of its bank or of all banks cuts it
    if (acc_rd) begin
      slot            = 1'b1;
      slot_b          = lnk.bank;
      slot_c          = lnk.col;
      s_next.rd_bank  = lnk.bank;
      s_next.rd_col   = lnk.col;
      s_next.rd_left  = PAIRS - 1'b1;
    end else if (s_reg.rd_left != '0 && lnk.cmd != CMD_BST && lnk.cmd != CMD_WRITE
                 && !pre_hit(lnk.cmd, lnk.auto_pre, lnk.bank, s_reg.rd_bank)) begin
      slot            = 1'b1;
      slot_c          = CW'(s_reg.rd_col + 2'h2);
      s_next.rd_col   = slot_c;
      s_next.rd_left  = s_reg.rd_left - 1'b1;
    end else begin
      s_next.rd_left  = '0;
    end

    // Latency pipe: pair appears CL cycles after its slot
    s_next.pv[0] = slot;
    s_next.pb[0] = slot_b;
    s_next.pc[0] = slot_c;
    for (int j = 1; j < PL; j++) begin
      s_next.pv[j] = s_reg.pv[j-1];
      s_next.pb[j] = s_reg.pb[j-1];
      s_next.pc[j] = s_reg.pc[j-1];
    end

    // Read drive: data with strobe high then low in each lane, one-cycle preamble
    s_next.dq_oe  = s_reg.pv[PL-1];
    s_next.dq     = s_reg.pv[PL-1] ? {mem[ra1], mem[ra0]} : '0;
    s_next.dqs    = s_reg.pv[PL-1] ? {NB{`MDB_STB_DATA}} : {NB{`MDB_STB_IDLE}};
    s_next.dqs_oe = s_reg.pv[PL-1] || s_reg.pv[PL-2];

    // Write pair slots: data follows the command by one cycle
    for (int l = 0; l < NB; l++) begin
      s_next.stb_last[l] = lnk.dqs_bus[2*l+1];
    end
    if (acc_wr) begin
      s_next.wr_act  = 1'b1;
      s_next.wr_bank = lnk.bank;
      s_next.wr_col  = lnk.col;
      s_next.wr_left = PAIRS - 1'b1;
    end else if (s_reg.wr_act && s_reg.wr_left != '0 && lnk.cmd != CMD_READ
                 && lnk.cmd != CMD_PRE) begin
      s_next.wr_col  = CW'(s_reg.wr_col + 2'h2);
      s_next.wr_left = s_reg.wr_left - 1'b1;
    end else begin
      s_next.wr_act  = 1'b0;
      s_next.wr_left = '0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Array writes with per-byte enables
  always_ff @(posedge i_clk) begin
    for (int l = 0; l < NB; l++) begin
      if (we0[l]) begin
        mem[wa0][8*l +: 8] <= lnk.dq_bus[8*l +: 8];
      end
      if (we1[l]) begin
        mem[wa1][8*l +: 8] <= lnk.dq_bus[DW + 8*l +: 8];
      end
    end
  end

  assign lnk.dq_d       = s_reg.dq;
  assign lnk.dq_d_oe    = s_reg.dq_oe;
  assign lnk.dqs_d      = s_reg.dqs;
  assign lnk.dqs_d_oe   = s_reg.dqs_oe;
  assign o_bank_open    = s_reg.open;
  assign o_write_active = s_reg.wr_act;

endmodule : mdb_dev

// ### hw/mdb_host.sv
// Controller end: issues commands, drives write bursts, gathers read pairs.
// Assumes the device answers with read latency CL on the same clock.
`timescale 1ns/1ns
`include "mdb_regs.svh"
module mdb_host #(
  parameter int DW = 32,
  parameter int CW = 4,
  parameter int BL = 4,
  parameter int CL = 3
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  mdb_link_if.host                    lnk,
  input  wire logic                   i_req_valid,
  input  wire mdb_pkg::mdb_cmd_type   i_req_cmd,
  input  wire logic [1:0]             i_req_bank,
  input  wire logic [CW-1:0]          i_req_col,
  input  wire logic                   i_req_auto_pre,
  input  wire logic [4:0]             i_req_pairs,
  input  wire logic [2*DW-1:0]        i_req_wdata,
  input  wire logic [DW/4-1:0]        i_req_wmask,
  output logic                        o_req_ready,
  output logic                        o_req_ack,
  output logic                        o_rd_valid,
  output logic [2*DW-1:0]             o_rd_data
);
  import mdb_pkg::*;

  localparam int NB = DW / 8;
  localparam logic [4:0] PAIRS = 5'(BL / 2);
  localparam logic [`MDB_CNT_W-1:0] TRP_C  = `MDB_CNT_W'(`MDB_CYC_UP(`MDB_TRP_NS));
  localparam logic [`MDB_CNT_W-1:0] TWR_C  = `MDB_CNT_W'(`MDB_CYC_UP(`MDB_TWR_NS));
  localparam logic [`MDB_CNT_W-1:0] WRITE_TO_READ_INTERVAL_C = `MDB_CNT_W'(`MDB_CYC_UP(`MDB_WRITE_TO_READ_INTERVAL_NS));
  localparam logic [`MDB_CNT_W-1:0] CL_C   = `MDB_CNT_W'(CL);

  typedef struct packed {
    mdb_cmd_type            cmd;
    logic [1:0]             bank;
    logic [CW-1:0]          col;
    logic                   ap;
    logic                   ready;
    logic                   ack;
    logic                   bst_pend;
    logic [`MDB_CNT_W-1:0]  gap;
    logic [`MDB_CNT_W-1:0]  rd_busy;
    logic [`MDB_CNT_W-1:0]  wtr;
    logic [`MDB_CNT_W-1:0]  wr;
    logic [`MDB_CNT_W-1:0]  rp;
    logic [4:0]             w_left;
    logic [4:0]             w_idx;
    logic [4:0]             w_pairs;
    logic [2*DW-1:0]        w_data;
    logic [2*NB-1:0]        w_mask;
    logic [2*DW-1:0]        dq;
    logic                   dq_oe;
    logic [2*NB-1:0]        dqs;
    logic                   dqs_oe;
    logic [2*NB-1:0]        mask;
    logic                   rd_valid;
    logic [2*DW-1:0]        rd_data;
  } mdb_host_state_type;

  mdb_host_state_type  s_reg;
  mdb_host_state_type  s_next;
  logic [4:0]          p;
  logic                legal;
  logic                acc;

  // Wanted pairs, clamped to one full burst
  assign p = (i_req_pairs == '0 || i_req_pairs > PAIRS) ? PAIRS : i_req_pairs;

  always_comb begin
    case (i_req_cmd)
      CMD_READ:  legal = s_reg.wtr == '0 && s_reg.rp == '0;
      CMD_WRITE: legal = s_reg.rd_busy == '0 && s_reg.rp == '0;
      CMD_PRE:   legal = s_reg.wr == '0;
      CMD_ACT:   legal = s_reg.rp == '0;
      default:   legal = 1'b1;
    endcase
  end

  assign acc = i_req_valid && s_reg.ready && legal;

  always_comb begin
    s_next     = s_reg;
    s_next.cmd = CMD_NOP;
    s_next.ack = acc;
    if (s_reg.rd_busy != '0) s_next.rd_busy = s_reg.rd_busy - 1'b1;
    if (s_reg.wtr != '0)     s_next.wtr     = s_reg.wtr - 1'b1;
    if (s_reg.wr != '0)      s_next.wr      = s_reg.wr - 1'b1;
    if (s_reg.rp != '0)      s_next.rp      = s_reg.rp - 1'b1;

    // Stop a shortened read without auto-precharge exactly wanted-pairs cycles after it
    if (s_reg.gap != '0) begin
      s_next.gap = s_reg.gap - 1'b1;
    end else if (s_reg.bst_pend) begin
      s_next.cmd      = CMD_BST;
      s_next.bst_pend = 1'b0;
      s_next.rd_busy  = CL_C + 1'b1;
    end

    // Write stream: one pair a cycle, pairs past the wanted count masked
    s_next.dq_oe  = s_reg.w_left != '0;
    s_next.dqs_oe = s_reg.w_left != '0 || s_reg.dq_oe;
    s_next.dqs    = {NB{`MDB_STB_IDLE}};
    s_next.mask   = '1;
    if (s_reg.w_left != '0) begin
      s_next.dq     = s_reg.w_data;
      s_next.dqs    = {NB{`MDB_STB_DATA}};
      s_next.mask   = (s_reg.w_idx < s_reg.w_pairs) ? s_reg.w_mask : '1;
      s_next.w_left = s_reg.w_left - 1'b1;
      s_next.w_idx  = s_reg.w_idx + 1'b1;
    end

    if (acc) begin
      s_next.cmd  = i_req_cmd;
      s_next.bank = i_req_bank;
      s_next.col  = i_req_col;
      s_next.ap   = i_req_auto_pre;
      case (i_req_cmd)
        CMD_READ: begin
          s_next.gap      = `MDB_CNT_W'(p - 1'b1);
          s_next.bst_pend = (p < PAIRS) && !i_req_auto_pre;
          s_next.rd_busy  = CL_C + `MDB_CNT_W'(p) + 1'b1;
        end
        CMD_WRITE: begin
          s_next.gap     = `MDB_CNT_W'(p - 1'b1);
          s_next.dqs_oe  = 1'b1;
          s_next.w_left  = PAIRS;
          s_next.w_idx   = '0;
          s_next.w_pairs = p;
          s_next.w_data  = i_req_wdata;
          s_next.w_mask  = i_req_wmask;
          s_next.wtr     = `MDB_CNT_W'(PAIRS) + WRITE_TO_READ_INTERVAL_C + 1'b1;
          s_next.wr      = `MDB_CNT_W'(PAIRS) + TWR_C + 1'b1;
        end
        CMD_PRE: begin
          s_next.rp = TRP_C;
        end
        default: begin
          s_next.gap = s_next.gap;
        end
      endcase
    end
    // Ready drops for the cycle after a take, so a held request is not taken twice
    s_next.ready = s_next.gap == '0 && !s_next.bst_pend && !acc;

    // Read capture on the device's strobe pattern in lane 0
    s_next.rd_valid = !s_reg.dqs_oe && lnk.dqs_bus[1:0] == `MDB_STB_DATA;
    s_next.rd_data  = s_next.rd_valid ? lnk.dq_bus : s_reg.rd_data;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign lnk.cmd             = s_reg.cmd;
  assign lnk.bank            = s_reg.bank;
  assign lnk.col             = s_reg.col;
  assign lnk.auto_pre        = s_reg.ap;
  assign lnk.dq_h            = s_reg.dq;
  assign lnk.dq_h_oe         = s_reg.dq_oe;
  assign lnk.dqs_h           = s_reg.dqs;
  assign lnk.dqs_h_oe        = s_reg.dqs_oe;
  assign lnk.byte_write_mask = s_reg.mask;
  assign o_req_ready         = s_reg.ready;
  assign o_req_ack           = s_reg.ack;
  assign o_rd_valid          = s_reg.rd_valid;
  assign o_rd_data           = s_reg.rd_data;

endmodule : mdb_host

// ### hw/mdb_link_if.sv
// Link between memory controller and low-power DDR data path.
// Assumes both ends run on one clock; one link cycle carries one data pair.
`timescale 1ns/1ns
interface mdb_link_if #(
  parameter int DW = 32,
  parameter int CW = 4
);
  localparam int NB = DW / 8;

  mdb_pkg::mdb_cmd_type  cmd;
  logic [1:0]            bank;
  logic [CW-1:0]         col;
  logic                  auto_pre;
  logic [2*NB-1:0]       byte_write_mask;
  logic [2*DW-1:0]       dq_h;
  logic                  dq_h_oe;
  logic [2*DW-1:0]       dq_d;
  logic                  dq_d_oe;
  logic [2*DW-1:0]       dq_bus;
  logic [2*NB-1:0]       dqs_h;
  logic                  dqs_h_oe;
  logic [2*NB-1:0]       dqs_d;
  logic                  dqs_d_oe;
  logic [2*NB-1:0]       dqs_bus;

  // Wire level from the enables; an undriven wire reads low
  assign dq_bus  = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : '0);
  assign dqs_bus = dqs_d_oe ? dqs_d : (dqs_h_oe ? dqs_h : '0);

  modport dev (
    input  cmd, bank, col, auto_pre, byte_write_mask, dq_bus, dqs_bus,
    output dq_d, dq_d_oe, dqs_d, dqs_d_oe
  );

  modport host (
    output cmd, bank, col, auto_pre, byte_write_mask, dq_h, dq_h_oe, dqs_h, dqs_h_oe,
    input  dq_bus, dqs_bus
  );

endinterface : mdb_link_if

// ### hw/mdb_pkg.sv
// Types shared by both ends of the burst data path.
// Assumes nothing beyond a SystemVerilog compiler.
package mdb_pkg;

  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACT,
    CMD_READ,
    CMD_WRITE,
    CMD_BST,
    CMD_PRE
  } mdb_cmd_type;

endpackage : mdb_pkg

// ### hw/mdb_regs.svh
// Named constants of the burst data path: clock, timing and strobe patterns.
// Assumes the link runs on the single system clock of 8 ns.
`ifndef MDB_REGS_SVH
`define MDB_REGS_SVH

`define MDB_CLK_NS    8
`define MDB_ROW_ACTIVE_TIME_NS   42
`define MDB_TRP_NS    18
`define MDB_TWR_NS    15
`define MDB_WRITE_TO_READ_INTERVAL_NS   16
`define MDB_CYC_UP(ns) ((((ns) + `MDB_CLK_NS - 1) / `MDB_CLK_NS) < 1 ? 1 : \
                        (((ns) + `MDB_CLK_NS - 1) / `MDB_CLK_NS))
`define MDB_NBANK     4
`define MDB_STB_DATA  2'h1
`define MDB_STB_IDLE  2'h0
`define MDB_CNT_W     8

`endif

// ### tb/mdb_link_properties.sv
// Concurrent checks on the link between controller end and device end.
// Assumes one clock, reset active high, parameters matching both ends.
`timescale 1ns/1ns
module mdb_link_properties #(
  parameter int DW = 32,
  parameter int BL = 4,
  parameter int CL = 3
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire mdb_pkg::mdb_cmd_type cmd,
  input  wire logic                 dq_h_oe,
  input  wire logic                 dq_d_oe,
  input  wire logic                 dqs_h_oe,
  input  wire logic                 dqs_d_oe,
  input  wire logic [DW/4-1:0]      dqs_bus
);
  import mdb_pkg::*;
  localparam int              NB       = DW / 8;
  localparam int              HB       = BL / 2;
  localparam logic [DW/4-1:0] STB_DATA = {NB{2'h1}};
  logic       rd_cmd;
  logic       wr_cmd;
  logic       bst_cmd;
  logic [7:0] run_h_reg;

  assign rd_cmd  = (cmd == CMD_READ);
  assign wr_cmd  = (cmd == CMD_WRITE);
  assign bst_cmd = (cmd == CMD_BST);

  // Length of the current run of host data cycles
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      run_h_reg <= 8'h00;
    end else if (dq_h_oe) begin
      run_h_reg <= run_h_reg + 8'h01;
    end else begin
      run_h_reg <= 8'h00;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_read_latency: assert property ($rose(dq_d_oe) |-> $past(rd_cmd, CL))
    else $error("read data did not start read latency after a read");
  a_read_preamble: assert property ($rose(dq_d_oe) |->
    $past(dqs_d_oe) && $past(dqs_bus) == '0)
    else $error("read data without a low strobe preamble");
  a_read_lane_strobes: assert property (dq_d_oe |-> dqs_d_oe && dqs_bus == STB_DATA)
    else $error("read pair without strobe toggling on every lane");
  a_write_first_edge: assert property (wr_cmd |=>
    dq_h_oe && dqs_h_oe && dqs_bus == STB_DATA)
    else $error("first write pair not one clock after write");
  a_write_postamble: assert property ($fell(dq_h_oe) |-> dqs_h_oe && dqs_bus == '0)
    else $error("write burst without a low strobe postamble");
  a_write_whole_bursts: assert property ($fell(dq_h_oe) |-> (int'(run_h_reg) % HB) == 0)
    else $error("write data run not a whole number of bursts");
  a_no_bus_fight: assert property (!(dq_d_oe && dq_h_oe) && !(dqs_d_oe && dqs_h_oe))
    else $error("both ends drive the data or strobe lines");
  a_stop_ends_read: assert property (bst_cmd |-> ##CL !dq_d_oe)
    else $error("read data continued past a burst stop");

  c_read: cover property (rd_cmd ##CL dq_d_oe);
  c_write: cover property (wr_cmd ##1 dq_h_oe);
  c_stop: cover property (bst_cmd);
  c_pre: cover property (cmd == CMD_PRE);
endmodule : mdb_link_properties

// ### tb/testbench.sv
// Self-checking bench: controller end and device end joined by the link interface.
// Assumes the design files compiled first; one 125 MHz clock, reset active high.
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    checked++; \
    if ((got) !== (ex)) begin \
      num_errors++; \
      $display("[ERR] %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module testbench;
  import mdb_pkg::*;
  localparam int DW  = 32;
  localparam int CW  = 4;
  localparam int BL  = 4;
  localparam int CL  = 3;
  localparam int NB  = DW / 8;
  localparam int HB  = BL / 2;
  localparam int GAP = 14;
  logic            i_clk;
  logic            i_rst;
  logic            i_req_valid;
  mdb_cmd_type     i_req_cmd;
  logic [1:0]      i_req_bank;
  logic [CW-1:0]   i_req_col;
  logic            i_req_auto_pre;
  logic [4:0]      i_req_pairs;
  logic [2*DW-1:0] i_req_wdata;
  logic [2*NB-1:0] i_req_wmask;
  logic            o_req_ready;
  logic            o_req_ack;
  logic            o_rd_valid;
  logic [2*DW-1:0] o_rd_data;
  logic [3:0]      o_bank_open;
  logic            o_write_active;
  logic [DW-1:0]   mem [4][2**CW];
  logic [2*DW-1:0] expq [$];
  int              num_errors;
  int              checked;
  int              seed;

  mdb_link_if #(.DW(DW), .CW(CW)) mdb_link_if_inst ();
  mdb_host #(.DW(DW), .CW(CW), .BL(BL), .CL(CL)) mdb_host_inst (
    .i_clk(i_clk), .i_rst(i_rst), .lnk(mdb_link_if_inst),
    .i_req_valid(i_req_valid), .i_req_cmd(i_req_cmd), .i_req_bank(i_req_bank),
    .i_req_col(i_req_col), .i_req_auto_pre(i_req_auto_pre), .i_req_pairs(i_req_pairs),
    .i_req_wdata(i_req_wdata), .i_req_wmask(i_req_wmask), .o_req_ready(o_req_ready),
    .o_req_ack(o_req_ack), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data));
  mdb_dev #(.DW(DW), .CW(CW), .BL(BL), .CL(CL)) mdb_dev_inst (
    .i_clk(i_clk), .i_rst(i_rst), .lnk(mdb_link_if_inst),
    .o_bank_open(o_bank_open), .o_write_active(o_write_active));
  mdb_link_properties #(.DW(DW), .BL(BL), .CL(CL)) mdb_link_properties_inst (
    .i_clk(i_clk), .i_rst(i_rst), .cmd(mdb_link_if_inst.cmd),
    .dq_h_oe(mdb_link_if_inst.dq_h_oe), .dq_d_oe(mdb_link_if_inst.dq_d_oe),
    .dqs_h_oe(mdb_link_if_inst.dqs_h_oe), .dqs_d_oe(mdb_link_if_inst.dqs_d_oe),
    .dqs_bus(mdb_link_if_inst.dqs_bus));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, input logic [DW-1:0] d,
                                          input logic [NB-1:0] m);
    logic [DW-1:0] r;
    r = o;
    for (int i = 0; i < NB; i++) begin
      if (!m[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [2*DW-1:0] pair_of(input int b, input int c, input int n);
    return {mem[b][c+2*n+1], mem[b][c+2*n]};
  endfunction : pair_of

  // Present one request and hold it until acknowledged
  task automatic req(input mdb_cmd_type c, input logic [1:0] b, input logic [CW-1:0] col,
                     input logic ap, input logic [4:0] p, input logic [2*DW-1:0] d,
                     input logic [2*NB-1:0] m, input int gap, input bit keep);
    int n;
    repeat (gap) @(posedge i_clk);
    i_req_valid    <= 1'b1;
    i_req_cmd      <= c;
    i_req_bank     <= b;
    i_req_col      <= col;
    i_req_auto_pre <= ap;
    i_req_pairs    <= p;
    i_req_wdata    <= d;
    i_req_wmask    <= m;
    n = 0;
    @(negedge i_clk);
    while (o_req_ack !== 1'b1 && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 100) begin
      num_errors++;
      $display("[ERR] req_ack expected 1 seen timeout");
      final_report();
    end
    `CHK("link_cmd", c, mdb_link_if_inst.cmd)
    @(posedge i_clk);
    if (!keep) begin
      i_req_valid <= 1'b0;
    end
  endtask : req

  task automatic wr(input int b, input int c, input logic [4:0] p, input bit rm, input int gap,
                    input bit keep);
    logic [2*DW-1:0] d;
    logic [2*NB-1:0] m;
    int              np;
    d  = {$random(seed), $random(seed)};
    m  = rm ? (2*NB)'($random(seed)) : '0;
    np = (p == 0 || p > HB) ? HB : p;
    for (int n = 0; n < np; n++) begin
      mem[b][c+2*n]   = merge(mem[b][c+2*n], d[DW-1:0], m[NB-1:0]);
      mem[b][c+2*n+1] = merge(mem[b][c+2*n+1], d[2*DW-1:DW], m[2*NB-1:NB]);
    end
    req(CMD_WRITE, 2'(b), CW'(c), 1'b0, p, d, m, gap, keep);
  endtask : wr

  task automatic collect();
    logic [2*DW-1:0] e;
    repeat (CL + BL + 6) begin
      @(negedge i_clk);
      if (o_rd_valid === 1'b1) begin
        e = expq.size() > 0 ? expq.pop_front() : 'x;
        `CHK("rd_data", e, o_rd_data)
      end
    end
    `CHK("rd_pairs_left", 0, expq.size())
    expq.delete();
  endtask : collect

  task automatic rd(input int b, input int c, input logic [4:0] p, input logic ap, input int np);
    for (int n = 0; n < np; n++) begin
      expq.push_back(pair_of(b, c, n));
    end
    req(CMD_READ, 2'(b), CW'(c), ap, p, '0, '0, GAP, 1'b0);
    @(negedge i_clk);
    if (p == 5'h01) begin
      `CHK("stop_cmd", CMD_BST, mdb_link_if_inst.cmd)
    end
    collect();
  endtask : rd

  initial begin
    int c;
    seed           = 718;
    num_errors     = 0;
    checked        = 0;
    i_rst          = 1'b1;
    i_req_valid    = 1'b0;
    i_req_cmd      = CMD_NOP;
    i_req_bank     = 2'h0;
    i_req_col      = '0;
    i_req_auto_pre = 1'b0;
    i_req_pairs    = 5'h00;
    i_req_wdata    = '0;
    i_req_wmask    = '0;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int b = 0; b < 4; b++) begin
      c = ({$random(seed)} % 4) * 4;
      req(CMD_ACT, 2'(b), '0, 1'b0, 5'h00, '0, '0, GAP, 1'b0);
      wr(b, c, 5'h00, 1'b0, GAP, 1'b0);
      wr(b, c, 5'({$random(seed)} % 2), 1'b1, GAP, 1'b0);
      rd(b, c, 5'h00, 1'b0, HB);
      rd(b, c, 5'h01, 1'b0, 1);
      `CHK("bank_open", 1'b1, o_bank_open[b])
      rd(b, c, 5'h00, 1'b1, HB);
      repeat (GAP) @(posedge i_clk);
      @(negedge i_clk);
      `CHK("bank_open", 1'b0, o_bank_open[b])
    end
    req(CMD_ACT, 2'h1, '0, 1'b0, 5'h00, '0, '0, GAP, 1'b0);
    wr(1, 0, 5'h00, 1'b0, GAP, 1'b1);
    wr(1, 4, 5'h00, 1'b1, 0, 1'b0);
    for (int n = 0; n < HB; n++) begin
      expq.push_back(pair_of(1, 0, n));
    end
    for (int n = 0; n < HB; n++) begin
      expq.push_back(pair_of(1, 4, n));
    end
    req(CMD_READ, 2'h1, CW'(0), 1'b0, 5'h00, '0, '0, GAP, 1'b1);
    req(CMD_READ, 2'h1, CW'(4), 1'b0, 5'h00, '0, '0, 0, 1'b0);
    collect();
    // Precharge two cycles after a read still yields both pairs
    for (int n = 0; n < HB; n++) begin
      expq.push_back(pair_of(1, 0, n));
    end
    req(CMD_READ, 2'h1, CW'(0), 1'b0, 5'h00, '0, '0, GAP, 1'b1);
    req(CMD_PRE, 2'h1, '0, 1'b0, 5'h00, '0, '0, 0, 1'b0);
    collect();
    repeat (GAP) @(posedge i_clk);
    @(negedge i_clk);
    `CHK("bank_open", 1'b0, o_bank_open[1])
    rd(1, 0, 5'h00, 1'b0, 0);
    final_report();
  end
endmodule : testbench
